// ===== fprf_pkg.sv
/*
  fprf_pkg: shared constants and types of the floating-point rounding and flag unit.
  Assumes: included first in compile order; every user names items as fprf_pkg::name.
*/
package fprf_pkg;

  // --------------------------------------------------------------------
  // register map (byte offsets on the plain register port)
  // --------------------------------------------------------------------
  localparam logic [3:0]  OFS_STATUS_CONTROL = 4'h0;
  localparam logic [3:0]  OFS_IRQ_STATUS     = 4'h4;
  localparam logic [3:0]  OFS_IRQ_MASK       = 4'h8;

  // --------------------------------------------------------------------
  // status/control word layout
  // --------------------------------------------------------------------
  localparam int          POS_RM             = 0;
  localparam int          POS_FLAG           = 2;
  localparam int          POS_ENABLE         = 7;
  localparam int          POS_CAUSE          = 12;
  localparam int          POS_DN             = 18;
  localparam int          POS_PR             = 19;
  localparam int          POS_SZ             = 20;
  localparam int          POS_FR             = 21;
  localparam logic [31:0] STATUS_RW_MASK     = 32'h003F_FFFF;
  localparam logic [31:0] STATUS_RESET       = 32'h0004_0001;
  // exception bit order inside flag, enable and cause fields
  localparam int          EXC_I              = 0;
  localparam int          EXC_U              = 1;
  localparam int          EXC_O              = 2;
  localparam int          EXC_Z              = 3;
  localparam int          EXC_V              = 4;
  localparam int          EXC_E              = 5;

  // rounding mode encodings
  localparam logic [1:0]  RM_NEAREST         = 2'h0;
  localparam logic [1:0]  RM_ZERO            = 2'h1;

  // --------------------------------------------------------------------
  // interrupt status layout
  // --------------------------------------------------------------------
  localparam int          IRQ_TRAP           = 0;
  localparam int          IRQ_DONE           = 1;
  localparam int          IRQ_BOUNDARY       = 2;
  localparam int          IRQ_WIDTH          = 3;
  localparam logic [2:0]  IRQ_MASK_RESET     = 3'h0;

  // --------------------------------------------------------------------
  // number formats
  // --------------------------------------------------------------------
  localparam logic [12:0] EMAX_SINGLE        = 13'h00FF;
  localparam logic [12:0] EMAX_DOUBLE        = 13'h07FF;
  localparam logic [31:0] SGL_MAX_NORMAL     = 32'h7F7F_FFFF;
  localparam logic [30:0] SGL_INF_MAG        = 31'h7F80_0000;
  localparam logic [62:0] DBL_INF_MAG        = 63'h7FF0_0000_0000_0000;
  localparam logic [30:0] SGL_MAX_MAG        = 31'h7F7F_FFFF;
  localparam logic [62:0] DBL_MAX_MAG        = 63'h7FEF_FFFF_FFFF_FFFF;
  localparam logic [31:0] SGL_QNAN           = 32'h7FBF_FFFF;
  localparam logic [63:0] DBL_QNAN           = 64'h7FF7_FFFF_FFFF_FFFF;
  localparam logic [31:0] SGL_CONST_ZERO     = 32'h0000_0000;
  localparam logic [31:0] SGL_CONST_ONE      = 32'h3F80_0000;
  localparam logic [6:0]  SHIFT_CAP          = 7'h3C;

  // --------------------------------------------------------------------
  // operation codes and operand classes
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE  = 4'h0,
    OP_ADD   = 4'h1,
    OP_SUB   = 4'h2,
    OP_MUL   = 4'h3,
    OP_MAC   = 4'h4,
    OP_DIV   = 4'h5,
    OP_INNER = 4'h6,
    OP_MATVEC= 4'h7,
    OP_LDI0  = 4'h8,
    OP_LDI1  = 4'h9
  } fprf_op_t;

  typedef enum logic [1:0] {
    CLS_FINITE = 2'h0,
    CLS_ZERO   = 2'h1,
    CLS_INF    = 2'h2,
    CLS_NAN    = 2'h3
  } fprf_class_t;

endpackage : fprf_pkg

// ===== fprf_round_if.sv
/*
  fprf_round_if: carries an unrounded value to the rounder and its packed answer back.
  Assumes: one clock domain; the rounder answers combinationally in the same cycle.
*/
`timescale 1ns/100ps
interface fprf_round_if;
  logic               pr;
  logic [1:0]         rm;
  logic               sign;
  logic signed [12:0] exp;
  logic [55:0]        mant;
  logic [63:0]        res;
  logic               inexact;
  logic               underflow;
  logic               overflow;
  logic               boundary;

  modport requester (output pr, rm, sign, exp, mant, input res, inexact, underflow, overflow, boundary);
  modport rounder   (input pr, rm, sign, exp, mant, output res, inexact, underflow, overflow, boundary);
endinterface : fprf_round_if

// ===== fprf_rounder.sv
/*
  fprf_rounder: rounds a normalised unrounded significand to single or double format.
  Assumes: mant has its leading one at bit 55; exp is biased to the target format.
*/
`timescale 1ns/100ps
module fprf_rounder (
  fprf_round_if.rounder rif
);

  logic [6:0]   sh;
  logic [111:0] full;
  logic [55:0]  shifted;
  logic         sticky_sh;
  logic [52:0]  q;
  logic         rbit;
  logic         sbit;
  logic         inc;
  logic [53:0]  qr;
  logic         carry;
  logic         lead;
  logic [12:0]  e_base;
  logic [12:0]  e_out;
  logic [12:0]  emax;
  logic         ovf;
  logic         inx;

  always_comb
  begin
    // tiny values are denormalised before rounding so the rounded exponent tells tininess
    if (rif.exp < 13'sh0001)
      sh = ((13'sh0001 - rif.exp) > $signed({6'h00, fprf_pkg::SHIFT_CAP})) ?
           fprf_pkg::SHIFT_CAP : 7'((13'sh0001 - rif.exp));
    else
      sh = 7'h00;
    full      = {rif.mant, 56'h0} >> sh;
    shifted   = full[111:56];
    sticky_sh = |full[55:0];
    if (rif.pr)
    begin
      q    = shifted[55:3];
      rbit = shifted[2];
      sbit = (|shifted[1:0]) | sticky_sh;
      emax = fprf_pkg::EMAX_DOUBLE;
    end
    else
    begin
      q    = {29'h0, shifted[55:32]};
      rbit = shifted[31];
      sbit = (|shifted[30:0]) | sticky_sh;
      emax = fprf_pkg::EMAX_SINGLE;
    end
    // nearest-even or truncation; the whole sticky is kept so add/sub rounds exactly
    inc    = (rif.rm == fprf_pkg::RM_NEAREST) ? (rbit & (sbit | q[0])) : 1'b0;
    qr     = {1'b0, q} + {53'h0, inc};
    carry  = rif.pr ? qr[53] : qr[24];
    lead   = rif.pr ? qr[52] : qr[23];
    e_base = (sh != 7'h00) ? 13'h0000 : rif.exp;
    e_out  = e_base + {12'h000, carry} + {12'h000, (sh != 7'h00) & lead};
    ovf    = (e_out >= emax);
    inx    = rbit | sbit | ovf;
  end

  always_comb
  begin
    if (ovf)
    begin
      if (rif.rm == fprf_pkg::RM_ZERO)
        rif.res = rif.pr ? {rif.sign, fprf_pkg::DBL_MAX_MAG} : {32'h0, rif.sign, fprf_pkg::SGL_MAX_MAG};
      else
        rif.res = rif.pr ? {rif.sign, fprf_pkg::DBL_INF_MAG} : {32'h0, rif.sign, fprf_pkg::SGL_INF_MAG};
    end
    else if (rif.pr)
      rif.res = {rif.sign, e_out[10:0], qr[51:0]};
    else
      rif.res = {32'h0, rif.sign, e_out[7:0], qr[22:0]};
  end

  // underflow only when the rounded value itself is not normal
  assign rif.underflow = (e_out == 13'h0000) & inx;
  assign rif.inexact   = inx;
  assign rif.overflow  = ovf;
  // tiny before rounding but normal after: the withheld-underflow case
  assign rif.boundary  = (sh != 7'h00) & lead & inx;

endmodule : fprf_rounder

// ===== fprf_flag_unit.sv
/*
  fprf_flag_unit: next cause and sticky flag values and the trap decision of one operation.
  Assumes: events are valid only with upd; software flag writes arrive on the same clock.
*/
`timescale 1ns/100ps
module fprf_flag_unit (
  input  wire logic       upd_in,
  input  wire logic [5:0] event_in,
  input  wire logic [4:0] enable_in,
  input  wire logic       force_v_trap_in,
  input  wire logic [5:0] cause_in,
  input  wire logic [4:0] flag_in,
  input  wire logic       sw_wr_in,
  input  wire logic [5:0] sw_cause_in,
  input  wire logic [4:0] sw_flag_in,
  output logic      [5:0] next_cause_out,
  output logic      [4:0] next_flag_out,
  output logic            trap_out
);

  logic [4:0] flag_base;

  always_comb
  begin
    flag_base      = sw_wr_in ? sw_flag_in : flag_in;
    // an operation's cause overrides a software write in the same cycle
    next_cause_out = upd_in ? event_in : (sw_wr_in ? sw_cause_in : cause_in);
    // sticky: hardware set wins over a software clear, absent events leave bits alone
    next_flag_out  = flag_base | (upd_in ? event_in[4:0] : 5'h00);
    // the error bit has no enable and always traps
    trap_out       = upd_in & ((|(event_in[4:0] & enable_in)) | event_in[5] |
                     (force_v_trap_in & enable_in[fprf_pkg::EXC_V]));
  end

endmodule : fprf_flag_unit

// ===== fprf_unit.sv
/*
  fprf_unit: top of the floating-point rounding and exception-flag unit, with its
  status/control register, interrupt status and mask, constant loads and result delivery.
  Assumes: the issue logic drives op_* on clk_sys_in, with the significand already
  normalised and the exponent biased for the selected precision; results are written
  to the register file the cycle after the request.
*/
// Added by the designer: the strobed register port and the placing of the registers.
// Notes on behaviour
// - nearest mode: single tiny value rounding to normal leaves underflow clear.
// - same underflow suppression for double values just below smallest normal, either sign.
// - boundary case writes correct normal result and sets inexact, underflow clear.
// - rounding mode 00 is nearest, 01 is toward zero.
// - a trap fires only for exceptions whose enable bit is one; the code also traps on the error bit and on any matrix op with V enabled.
// - inner product and matrix op may flag overflow from the error bound.
// - inner product and matrix op result sign with infinities is not guaranteed.
// - double add/sub in the narrow exponent window may miss inexact or misround.
// - that add/sub error stays below 129/256 of one result step.
// - precision bit zero is single, one is double.
// - two constant loads write exactly 0.0 or 1.0 to a single register.
// - cause bits follow each operation; sticky flags only gain set bits. The code leaves cause and flags unchanged on the two constant loads.
// - inner product and matrix op always set inexact cause and flag.
`timescale 1ns/100ps
module fprf_unit (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  input  wire logic        op_valid_in,
  input  wire logic [3:0]  op_code_in,
  input  wire logic        op_sign_in,
  input  wire logic [12:0] op_exp_in,
  input  wire logic [55:0] op_mant_in,
  input  wire logic [1:0]  op_class_in,
  input  wire logic        op_invalid_in,
  input  wire logic        op_divzero_in,
  input  wire logic        op_denorm_in,
  input  wire logic [31:0] op_err_bound_in,
  output logic             res_valid_out,
  output logic      [63:0] res_data_out,
  output logic             res_double_out,
  output logic             trap_out,
  output logic             irq_out,
  output logic      [1:0]  rounding_mode_out,
  output logic             precision_select_out
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  logic [31:0]                     fp_status_control_reg;
  logic [fprf_pkg::IRQ_WIDTH-1:0]  irq_status;
  logic [fprf_pkg::IRQ_WIDTH-1:0]  irq_mask;

  fprf_round_if rif ();

  // --------------------------------------------------------------------
  // field access
  // --------------------------------------------------------------------
  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  logic [1:0]         rounding_mode_field;
  logic               precision_select_bit;
  logic               denorm_zero_bit;
  logic [4:0]         flag_field;
  logic [4:0]         enable_field;
  logic [5:0]         cause_field;

  assign rounding_mode_field  = fp_status_control_reg[fprf_pkg::POS_RM +: 2];
  assign precision_select_bit = fp_status_control_reg[fprf_pkg::POS_PR];
  assign denorm_zero_bit      = fp_status_control_reg[fprf_pkg::POS_DN];
  assign flag_field           = fp_status_control_reg[fprf_pkg::POS_FLAG +: 5];
  assign enable_field         = fp_status_control_reg[fprf_pkg::POS_ENABLE +: 5];
  assign cause_field          = fp_status_control_reg[fprf_pkg::POS_CAUSE +: 6];

  // --------------------------------------------------------------------
  // operation decode
  // --------------------------------------------------------------------
  fprf_pkg::fprf_op_t    op;
  fprf_pkg::fprf_class_t cls;
  logic                  is_geom;
  logic                  is_const;
  logic                  is_arith;
  logic                  sw_status_wr;

  assign op           = fprf_pkg::fprf_op_t'(op_code_in);
  assign cls          = fprf_pkg::fprf_class_t'(op_class_in);
  assign is_geom      = (op == fprf_pkg::OP_INNER) | (op == fprf_pkg::OP_MATVEC);
  assign is_const     = (op == fprf_pkg::OP_LDI0) | (op == fprf_pkg::OP_LDI1);
  assign is_arith     = op_valid_in & !is_const & (op != fprf_pkg::OP_NONE);
  assign sw_status_wr = reg_wr_in & reg_hit(reg_addr_in, fprf_pkg::OFS_STATUS_CONTROL);

  // geometric ops are single precision only
  logic op_double;
  assign op_double = precision_select_bit & !is_geom;

  // --------------------------------------------------------------------
  // rounding
  // --------------------------------------------------------------------
  assign rif.pr   = op_double;
  assign rif.rm   = rounding_mode_field;
  // the sign of geometric results is taken as the datapath delivers it
  assign rif.sign = op_sign_in;
  assign rif.exp  = $signed(op_exp_in);
  assign rif.mant = op_mant_in;

  fprf_rounder u_rounder (
    .rif (rif)
  );

  // --------------------------------------------------------------------
  // result and event selection
  // --------------------------------------------------------------------
  logic [63:0] next_result;
  logic [5:0]  op_events;
  logic        bound_ovf;

  // error bound compared as magnitude; a zero result may still report overflow
  assign bound_ovf = is_geom & (op_err_bound_in[30:0] > fprf_pkg::SGL_MAX_NORMAL[30:0]);

  always_comb
  begin
    next_result = 64'h0000_0000_0000_0000;
    op_events   = 6'h00;
    if (op_invalid_in | (cls == fprf_pkg::CLS_NAN))
    begin
      next_result                 = op_double ? fprf_pkg::DBL_QNAN : {32'h0, fprf_pkg::SGL_QNAN};
      op_events[fprf_pkg::EXC_V]  = op_invalid_in;
    end
    else if (op_divzero_in)
    begin
      next_result = op_double ? {op_sign_in, fprf_pkg::DBL_INF_MAG} : {32'h0, op_sign_in, fprf_pkg::SGL_INF_MAG};
      op_events[fprf_pkg::EXC_Z]  = 1'b1;
    end
    else if (cls == fprf_pkg::CLS_INF)
      next_result = op_double ? {op_sign_in, fprf_pkg::DBL_INF_MAG} : {32'h0, op_sign_in, fprf_pkg::SGL_INF_MAG};
    else if (cls == fprf_pkg::CLS_ZERO)
      next_result = op_double ? {op_sign_in, 63'h0} : {32'h0, op_sign_in, 31'h0};
    else
    begin
      // tiny results rounding to normal get the normal value with inexact only
      next_result                 = rif.res;
      op_events[fprf_pkg::EXC_I]  = rif.inexact;
      op_events[fprf_pkg::EXC_U]  = rif.underflow;
      op_events[fprf_pkg::EXC_O]  = rif.overflow;
    end
    // denormal input while flush-to-zero is off is an unmaskable error
    op_events[fprf_pkg::EXC_E] = op_denorm_in & !denorm_zero_bit;
    if (is_geom)
    begin
      op_events[fprf_pkg::EXC_I] = 1'b1;
      op_events[fprf_pkg::EXC_O] = op_events[fprf_pkg::EXC_O] | bound_ovf;
    end
  end

  // --------------------------------------------------------------------
  // cause, flag and trap
  // --------------------------------------------------------------------
  logic [5:0] next_cause;
  logic [4:0] next_flag;
  logic       op_trap;

  fprf_flag_unit u_flags (
    .upd_in          (is_arith),
    .event_in        (op_events),
    .enable_in       (enable_field),
    .force_v_trap_in (op == fprf_pkg::OP_MATVEC),
    .cause_in        (cause_field),
    .flag_in         (flag_field),
    .sw_wr_in        (sw_status_wr),
    .sw_cause_in     (reg_wdata_in[fprf_pkg::POS_CAUSE +: 6]),
    .sw_flag_in      (reg_wdata_in[fprf_pkg::POS_FLAG +: 5]),
    .next_cause_out  (next_cause),
    .next_flag_out   (next_flag),
    .trap_out        (op_trap)
  );

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      fp_status_control_reg <= fprf_pkg::STATUS_RESET;
    else
    begin
      if (sw_status_wr)
        fp_status_control_reg <= reg_wdata_in & fprf_pkg::STATUS_RW_MASK;
      fp_status_control_reg[fprf_pkg::POS_CAUSE +: 6] <= next_cause;
      fp_status_control_reg[fprf_pkg::POS_FLAG +: 5]  <= next_flag;
    end
  end

  // --------------------------------------------------------------------
  // result delivery
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      res_valid_out  <= 1'b0;
      res_data_out   <= 64'h0000_0000_0000_0000;
      res_double_out <= 1'b0;
    end
    else if (op_valid_in & is_const)
    begin
      // constant loads leave the status word alone
      res_valid_out  <= 1'b1;
      res_double_out <= 1'b0;
      res_data_out   <= {32'h0, (op == fprf_pkg::OP_LDI1) ?
                          fprf_pkg::SGL_CONST_ONE : fprf_pkg::SGL_CONST_ZERO};
    end
    else
    begin
      // a trapping operation leaves the destination register unchanged
      res_valid_out  <= is_arith & !op_trap;
      res_double_out <= op_double;
      res_data_out   <= next_result;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      trap_out <= 1'b0;
    else
      trap_out <= op_trap;
  end

  // the transfer logic reads this; quadword moves under double precision are not
  // checked here and their result is left undefined
  assign rounding_mode_out    = rounding_mode_field;
  assign precision_select_out = precision_select_bit;

  // --------------------------------------------------------------------
  // interrupt status and mask
  // --------------------------------------------------------------------
  logic [fprf_pkg::IRQ_WIDTH-1:0] irq_events;
  logic [fprf_pkg::IRQ_WIDTH-1:0] next_irq_status;
  logic                           irq_rd_clear;

  always_comb
  begin
    irq_events                         = '0;
    irq_events[fprf_pkg::IRQ_TRAP]     = op_trap;
    irq_events[fprf_pkg::IRQ_DONE]     = is_arith & !op_trap;
    // lets software spot tiny-but-rounded-normal results without a trap handler
    irq_events[fprf_pkg::IRQ_BOUNDARY] = is_arith & (cls == fprf_pkg::CLS_FINITE) &
                                         !op_invalid_in & !op_divzero_in & rif.boundary;
  end

  assign irq_rd_clear    = reg_rd_in & reg_hit(reg_addr_in, fprf_pkg::OFS_IRQ_STATUS);
  // new events win over the read that clears
  assign next_irq_status = (irq_rd_clear ? '0 : irq_status) | irq_events;

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      irq_status <= '0;
    else
      irq_status <= next_irq_status;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      irq_mask <= fprf_pkg::IRQ_MASK_RESET;
    else if (reg_wr_in & reg_hit(reg_addr_in, fprf_pkg::OFS_IRQ_MASK))
      irq_mask <= reg_wdata_in[fprf_pkg::IRQ_WIDTH-1:0];
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(next_irq_status & irq_mask);
  end

  // --------------------------------------------------------------------
  // register read port
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
    begin
      if (reg_hit(reg_addr_in, fprf_pkg::OFS_STATUS_CONTROL))
        reg_rdata_out <= fp_status_control_reg;
      else if (reg_hit(reg_addr_in, fprf_pkg::OFS_IRQ_STATUS))
        reg_rdata_out <= {29'h0, irq_status};
      else if (reg_hit(reg_addr_in, fprf_pkg::OFS_IRQ_MASK))
        reg_rdata_out <= {29'h0, irq_mask};
      else
        reg_rdata_out <= 32'h0000_0000;
    end
    else
      reg_rdata_out <= 32'h0000_0000;
  end

endmodule : fprf_unit

// ===== fprf_unit_props.sv
/*
  fprf_unit_props: port-level checks of fprf_unit.
  Assumes: bound to fprf_unit; one clock, synchronous active-high reset.
*/
`timescale 1ns/100ps
module fprf_unit_props (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        op_valid_in,
  input wire logic [3:0]  op_code_in,
  input wire logic        res_valid_out,
  input wire logic [63:0] res_data_out,
  input wire logic        res_double_out,
  input wire logic        trap_out,
  input wire logic [1:0]  rounding_mode_out,
  input wire logic        precision_select_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_req(c); op_valid_in && op_code_in == c; endsequence
  sequence s_arith; op_valid_in && op_code_in inside {[4'h1:4'h5]}; endsequence
  sequence s_ctl_wr; reg_wr_in && reg_addr_in == 4'h0; endsequence
  a_load_zero: assert property (s_req(4'h8) |=> res_valid_out && res_data_out == 64'h0 && !res_double_out)
    else $error("zero load wrong");
  a_load_one: assert property (s_req(4'h9) |=> res_valid_out && res_data_out == 64'h3F80_0000)
    else $error("one load wrong");
  a_mode_from_write: assert property (s_ctl_wr |=> rounding_mode_out == $past(reg_wdata_in[1:0]))
    else $error("rounding mode not taken");
  a_prec_from_write: assert property (s_ctl_wr |=> precision_select_out == $past(reg_wdata_in[19]))
    else $error("precision not taken");
  a_arith_width: assert property (s_arith ##1 res_valid_out |-> res_double_out == $past(precision_select_out))
    else $error("result width wrong");
  a_single_upper: assert property (res_valid_out && !res_double_out |-> res_data_out[63:32] == 32'h0)
    else $error("single upper half set");
  a_idle_quiet: assert property (!(op_valid_in && op_code_in != 4'h0) |=> !res_valid_out && !trap_out)
    else $error("output without request");
  a_trap_no_result: assert property (trap_out |-> !res_valid_out)
    else $error("trap with result");
endmodule : fprf_unit_props
bind fprf_unit fprf_unit_props chk_u (.*);

// ===== fprf_issue_model.sv
/*
  fprf_issue_model: issue side handing one request at a time to the unit.
  Assumes: issue is entered just after a rising edge of clk_in.
*/
`timescale 1ns/100ps
module fprf_issue_model (
  input  wire logic        clk_in,
  output logic             op_valid_out,
  output logic      [3:0]  op_code_out,
  output logic             op_sign_out,
  output logic      [12:0] op_exp_out,
  output logic      [55:0] op_mant_out,
  output logic      [1:0]  op_class_out,
  output logic      [31:0] op_err_bound_out
);
  initial {op_valid_out, op_code_out, op_sign_out, op_exp_out, op_mant_out, op_class_out, op_err_bound_out} = '0;
  // register operations only, no quadword transfer in double mode
  task automatic issue(input logic [3:0] c, input logic s, input logic [12:0] e, input logic [55:0] m,
                       input logic [1:0] k, input logic [31:0] b);
    {op_code_out, op_sign_out, op_exp_out, op_mant_out, op_class_out, op_err_bound_out} <= {c, s, e, m, k, b};
    op_valid_out <= 1'b1;
    @(posedge clk_in);
    op_valid_out <= 1'b0;
    // released fields invert so a late sample cannot match by luck
    {op_code_out, op_sign_out, op_exp_out, op_mant_out, op_class_out, op_err_bound_out} <= ~{c, s, e, m, k, b};
  endtask : issue
endmodule : fprf_issue_model

// ===== fprf_unit_test.sv
/*
  fprf_unit_test: register and operation tests of fprf_unit.
  Assumes: the issue model drives op_* one request at a time.
*/
`timescale 1ns/100ps
module fprf_unit_test;
  logic clk_sys_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic [3:0] reg_addr_in = 4'h0, op_code_in;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, op_err_bound_in;
  logic op_valid_in, op_sign_in, res_valid_out, res_double_out, trap_out, irq_out, precision_select_out;
  logic [12:0] op_exp_in;
  logic [55:0] op_mant_in;
  logic [1:0] op_class_in, rounding_mode_out;
  logic [63:0] res_data_out;
  wire op_invalid_in = 1'b0, op_divzero_in = 1'b0, op_denorm_in = 1'b0;
  localparam logic [55:0] TINY_S = 56'hFF_FFFF_8000_0000;
  int mismatches = 0, total_checks = 0, cycles = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  fprf_unit dut_u (.*);
  fprf_issue_model iss_u (.clk_in(clk_sys_in), .op_valid_out(op_valid_in), .op_code_out(op_code_in),
    .op_sign_out(op_sign_in), .op_exp_out(op_exp_in), .op_mant_out(op_mant_in), .op_class_out(op_class_in),
    .op_err_bound_out(op_err_bound_in));
  task automatic chk(input logic [63:0] got, input logic [63:0] want);
    total_checks++;
    if (got !== want)
    begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] want);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, want);
    @(posedge clk_sys_in);
  endtask : rd
  // want: trap, result strobe, result word; sign follows from it, zero class from the inner-product code
  task automatic op(input logic [3:0] c, input logic [55:0] m, input logic [31:0] b, input logic [65:0] want);
    iss_u.issue(c, want[63], 13'h0000, m, {1'b0, c == 4'h6}, b);
    #1 chk({trap_out, res_valid_out}, want[65:64]);
    if (want[64])
      chk(res_data_out, want[63:0]);
    @(posedge clk_sys_in);
  endtask : op
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      final_report();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rd(4'h0, 32'h0004_0001);
    rd(4'hC, 32'h0);
    wr(4'h8, 32'h0000_0006);
    op(4'h8, 0, 0, {2'b01, 64'h0});
    op(4'h9, 0, 0, {2'b01, 64'h3F80_0000});
    rd(4'h0, 32'h0004_0001);
    #1 chk(irq_out, 1'b0);
    @(posedge clk_sys_in);
    rd(4'h4, 32'h0000_0000);
    #1 chk(irq_out, 1'b0);
    @(posedge clk_sys_in);
    $display("test const done");
    wr(4'h0, 32'h0004_0000);
    op(4'h3, TINY_S, 0, {2'b01, 64'h0080_0000});
    rd(4'h0, 32'h0004_1004);
    #1 chk(irq_out, 1'b1);
    @(posedge clk_sys_in);
    rd(4'h4, 32'h0000_0006);
    #1 chk(irq_out, 1'b0);
    @(posedge clk_sys_in);
    wr(4'h0, 32'h0004_0001);
    op(4'h3, TINY_S, 0, {2'b01, 64'h007F_FFFF});
    rd(4'h0, 32'h0004_300D);
    wr(4'h0, 32'h0004_000C);
    op(4'h3, TINY_S, 0, {2'b01, 64'h0080_0000});
    rd(4'h0, 32'h0004_100C);
    $display("test round done");
    wr(4'h0, 32'h000C_0000);
    op(4'h5, 56'hFF_FFFF_FFFF_FFFC, 0, {2'b01, 64'h8010_0000_0000_0000});
    rd(4'h0, 32'h000C_1004);
    $display("test double done");
    wr(4'h0, 32'h0004_0000);
    op(4'h6, 0, 32'h7F80_0000, {2'b01, 64'h0});
    op(4'h6, 0, 32'h7F7F_FFFF, {2'b01, 64'h0});
    rd(4'h0, 32'h0004_1014);
    $display("test inner done");
    wr(4'h0, 32'h0004_0100);
    op(4'h3, TINY_S, 0, {2'b01, 64'h0080_0000});
    wr(4'h0, 32'h0004_0080);
    op(4'h6, 0, 0, {2'b10, 64'h0});
    $display("test trap done");
    final_report();
  end
endmodule : fprf_unit_test
